// ---- design/cdt_timers.sv ----
// Purpose: Ring of cascadable 16-bit down timer channels with pulse pins
// Assumes: Pins and setup inputs are synchronous to clock
// Notes:   Channel i takes channel i-1's underflows; channel 0 takes the last one's
`timescale 1ns/10ps
`default_nettype none
`include "cdt_consts.svh"

module cdt_timers #(
    parameter int NCH = `CDT_NCH_DEF,
    parameter int DIV = `CDT_DIV_DEF
) (
    // System
    input wire logic clock,
    input wire logic reset,
    // Channel setup
    input wire cdt_pkg::cdt_cfg_type [NCH-1:0] cfg,
    // Request handshake
    input wire logic [NCH-1:0] irq_clear,
    input wire logic [NCH-1:0] irq_ack,
    output logic [NCH-1:0] irq_request,
    // Pins
    input wire logic [NCH-1:0] timer_event_input_pin,
    input wire logic [NCH-1:0] pulse_pin_in,
    output logic [NCH-1:0] pulse_pin_out,
    output logic [NCH-1:0] pulse_pin_oe_n,
    output logic [NCH-1:0] port_level,
    // Status
    output cdt_pkg::cdt_stat_type [NCH-1:0] stat
);
    import cdt_pkg::*;

    localparam int DIVW = (DIV > 2) ? $clog2(DIV) : 1;

    // ****************************************
    // Elaboration checks
    // ****************************************
    if (NCH < 2) begin : g_bad_nch
        $error("cdt_timers needs at least two channels");
    end
    if (DIV < 2) begin : g_bad_div
        $error("cdt_timers prescaler must divide by two or more");
    end

    typedef struct packed {
        logic [NCH-1:0] evt_prev;
        logic [NCH-1:0] irq;
        logic [NCH-1:0] pin_out;
        logic [NCH-1:0] pin_oe_n;
        logic [NCH-1:0] port_level;
        logic [DIVW-1:0] div;
        logic tick;
    } cdt_top_state_type;

    cdt_top_state_type q;
    cdt_top_state_type d;
    logic [NCH-1:0] evt_fall;

    // ****************************************
    // Channels
    // ****************************************
    // Event pin idles high so a released pin never looks like a falling edge
    assign evt_fall = q.evt_prev & ~timer_event_input_pin;

    for (genvar i = 0; i < NCH; i++) begin : g_ch
        localparam int UP = (i == 0) ? NCH - 1 : i - 1;
        cdt_channel u_ch (
            .clock(clock),
            .reset(reset),
            .cfg(cfg[i]),
            .prescale_tick(q.tick),
            .ext_fall(evt_fall[i]),
            .upstream_uf(stat[UP].uf),
            .stat(stat[i])
        );
    end

    // ****************************************
    // Prescaler, requests and pins
    // ****************************************
    always_comb begin
        d = q;
        d.evt_prev = timer_event_input_pin;
        d.tick = 1'b0;
        if (q.div == DIVW'(DIV - 1)) begin
            d.div = '0;
            d.tick = 1'b1;
        end else begin
            d.div = q.div + DIVW'(1);
        end
        for (int i = 0; i < NCH; i++) begin
            d.irq[i] = (q.irq[i] & ~(irq_clear[i] | irq_ack[i])) | stat[i].uf;
            d.pin_out[i] = cfg[i].pulse_sel & stat[i].level;
            d.pin_oe_n[i] = ~cfg[i].pulse_sel;
            d.port_level[i] = cfg[i].pulse_sel ? q.port_level[i] : pulse_pin_in[i];
        end
    end

    always_ff @(posedge clock or posedge reset) begin
        if (reset) begin
            q <= '{evt_prev: '1, irq: '0, pin_out: '0, pin_oe_n: '1, port_level: '0, div: '0, tick: 1'b0};
        end else begin
            q <= d;
        end
    end

    assign irq_request = q.irq;
    assign pulse_pin_out = q.pin_out;
    assign pulse_pin_oe_n = q.pin_oe_n;
    assign port_level = q.port_level;

    // ****************************************
    // Checks
    // ****************************************
    default clocking cdt_cb @(posedge clock);
    endclocking
    default disable iff (reset);

    for (genvar i = 0; i < NCH; i++) begin : g_chk
        localparam int UP = (i == 0) ? NCH - 1 : i - 1;

        chk_timer_decrement: assert property (
            (stat[i].state == CDT_ST_COUNT && cfg[i].start && cfg[i].mode == CDT_MODE_TIMER
             && cfg[i].clk_undiv && stat[i].count != `CDT_CNT_ZERO)
            |=> stat[i].count == $past(stat[i].count) - `CDT_CNT_ONE)
            else $error("timer did not decrement on its tick");

        chk_timer_reload: assert property (
            (stat[i].state == CDT_ST_COUNT && cfg[i].start && cfg[i].mode == CDT_MODE_TIMER
             && cfg[i].clk_undiv && stat[i].count == `CDT_CNT_ZERO)
            |=> stat[i].uf && stat[i].count == $past(cfg[i].reload) && stat[i].state == CDT_ST_COUNT ##1 irq_request[i])
            else $error("timer underflow did not reload and request");

        chk_cascade_count: assert property (
            (stat[i].state == CDT_ST_COUNT && cfg[i].start && cfg[i].mode == CDT_MODE_EVENT
             && !cfg[i].evt_ext && stat[UP].uf && stat[i].count != `CDT_CNT_ZERO)
            |=> stat[i].count == $past(stat[i].count) - `CDT_CNT_ONE)
            else $error("cascade event not counted");

        chk_shot_trigger: assert property (
            (stat[i].state == CDT_ST_ARMED && cfg[i].start && stat[UP].uf)
            |=> stat[i].state == CDT_ST_SHOT && stat[i].level)
            else $error("one-shot did not start on trigger");

        chk_shot_end: assert property (
            (stat[i].uf && $past(stat[i].state) == CDT_ST_SHOT)
            |-> stat[i].state == CDT_ST_ARMED && !stat[i].level && stat[i].count == $past(cfg[i].reload)
                ##1 irq_request[i])
            else $error("one-shot end not handled");

        chk_pin_toggle: assert property (
            (cfg[i].pulse_sel && stat[i].uf && $past(stat[i].state) == CDT_ST_COUNT)
            |-> stat[i].level != $past(stat[i].level) ##1 pulse_pin_out[i] == $past(stat[i].level)
                && !pulse_pin_oe_n[i])
            else $error("pulse pin did not follow underflow");

        chk_pin_release: assert property (
            !cfg[i].pulse_sel |=> pulse_pin_oe_n[i] && !pulse_pin_out[i])
            else $error("pin driver not released");

        chk_ext_event: assert property (
            (stat[i].state == CDT_ST_COUNT && cfg[i].start && cfg[i].mode == CDT_MODE_EVENT && cfg[i].evt_ext
             && cfg[i].reload == `CDT_CNT_ZERO && stat[i].count == `CDT_CNT_ZERO && evt_fall[i])
            |=> stat[i].uf ##1 irq_request[i])
            else $error("event pin edge gave no underflow");

        chk_undiv_shot: assert property (
            (stat[i].state == CDT_ST_SHOT && cfg[i].start && cfg[i].clk_undiv
             && stat[i].count > `CDT_CNT_ONE)
            |=> stat[i].count == $past(stat[i].count) - `CDT_CNT_ONE)
            else $error("one-shot ignored undivided clock");

        chk_irq_sticky: assert property (
            (irq_request[i] && !irq_clear[i] && !irq_ack[i]) |=> irq_request[i])
            else $error("request bit dropped without clear");
    end

endmodule : cdt_timers
`default_nettype wire

// ---- design/cdt_consts.svh ----
// Purpose: Shared constants of the cascadable down timer channels
// Assumes: Included by the package and by every design file
// Notes:   Definitions only
`ifndef CDT_CONSTS_SVH
`define CDT_CONSTS_SVH

// ****************************************
// Widths and default sizes
// ****************************************
`define CDT_CNT_W 16
`define CDT_NCH_DEF 2
`define CDT_DIV_DEF 8

// ****************************************
// Counter values
// ****************************************
`define CDT_CNT_ZERO 16'h0000
`define CDT_CNT_ONE 16'h0001

`endif

// ---- design/cdt_pkg.sv ----
// Purpose: Types of the cascadable down timer channels
// Assumes: cdt_consts.svh holds the numbers
// Notes:   Channel state doubles as its status carrier
`include "cdt_consts.svh"

package cdt_pkg;

    // ****************************************
    // Modes and channel states
    // ****************************************
    typedef enum logic [1:0] {
        CDT_MODE_TIMER = 2'h0,
        CDT_MODE_EVENT = 2'h1,
        CDT_MODE_ONESHOT = 2'h2
    } cdt_mode_type;

    typedef enum logic [3:0] {
        CDT_ST_STOP = 4'h1,
        CDT_ST_COUNT = 4'h2,
        CDT_ST_ARMED = 4'h4,
        CDT_ST_SHOT = 4'h8
    } cdt_state_type;

    // ****************************************
    // Carriers
    // ****************************************
    typedef struct packed {
        logic start;
        cdt_mode_type mode;
        logic evt_ext;
        logic clk_undiv;
        logic pulse_sel;
        logic [`CDT_CNT_W-1:0] reload;
    } cdt_cfg_type;

    typedef struct packed {
        cdt_state_type state;
        logic [`CDT_CNT_W-1:0] count;
        logic uf;
        logic level;
    } cdt_stat_type;

endpackage : cdt_pkg

// ---- design/cdt_channel.sv ----
// Purpose: One 16-bit down counting timer channel
// Assumes: Ticks and triggers are one-cycle pulses on clock
// Notes:   The status output is the channel's own state register
`timescale 1ns/10ps
`default_nettype none
`include "cdt_consts.svh"

module cdt_channel (
    // System
    input wire logic clock,
    input wire logic reset,
    // Setup
    input wire cdt_pkg::cdt_cfg_type cfg,
    // Count sources
    input wire logic prescale_tick,
    input wire logic ext_fall,
    input wire logic upstream_uf,
    // Status
    output cdt_pkg::cdt_stat_type stat
);
    import cdt_pkg::*;

    cdt_stat_type q;
    cdt_stat_type d;
    logic tick;

    // ****************************************
    // Count source
    // ****************************************
    // source select
    assign tick = (cfg.mode == CDT_MODE_EVENT) ? (cfg.evt_ext ? ext_fall : upstream_uf)
                                               : (cfg.clk_undiv | prescale_tick);

    // ****************************************
    // Counter sequence
    // ****************************************
    always_comb begin
        d = q;
        d.uf = 1'b0;
        case (q.state)
            CDT_ST_STOP: begin
                // Stopped counter shows the reload value so the first period is whole
                d.count = cfg.reload;
                d.level = 1'b0;
                if (cfg.start) begin
                    d.state = (cfg.mode == CDT_MODE_ONESHOT) ? CDT_ST_ARMED : CDT_ST_COUNT;
                end
            end
            CDT_ST_COUNT: begin
                if (!cfg.start) begin
                    d.state = CDT_ST_STOP;
                end else if (tick) begin
                    if (q.count == `CDT_CNT_ZERO) begin
                        d.count = cfg.reload;
                        d.uf = 1'b1;
                        d.level = ~q.level;
                    end else begin
                        d.count = q.count - `CDT_CNT_ONE;
                    end
                end
            end
            CDT_ST_ARMED: begin
                if (!cfg.start) begin
                    d.state = CDT_ST_STOP;
                end else if (upstream_uf) begin
                    d.state = CDT_ST_SHOT;
                    d.level = 1'b1;
                end
            end
            CDT_ST_SHOT: begin
                if (!cfg.start) begin
                    d.state = CDT_ST_STOP;
                end else if (tick) begin
                    if (q.count == `CDT_CNT_ZERO || q.count == `CDT_CNT_ONE) begin
                        d.count = cfg.reload;
                        d.uf = 1'b1;
                        d.level = 1'b0;
                        d.state = CDT_ST_ARMED;
                    end else begin
                        d.count = q.count - `CDT_CNT_ONE;
                    end
                end
            end
            default: begin
                d.state = CDT_ST_STOP;
            end
        endcase
    end

    always_ff @(posedge clock or posedge reset) begin
        if (reset) begin
            q <= '{state: CDT_ST_STOP, count: `CDT_CNT_ZERO, uf: 1'b0, level: 1'b0};
        end else begin
            q <= d;
        end
    end

    assign stat = q;

endmodule : cdt_channel
`default_nettype wire

// ---- sim/cdt_timers_tb_top.sv ----
// Purpose: Self-checking bench of the cascadable down timer channels
// Assumes: NCH=2 and DIV=2 keep the prescaled runs short
// Notes:   Timer cases run from a table; reset and the rest are hand tests
`timescale 1ns/10ps
`default_nettype none
`include "cdt_consts.svh"

module cdt_timers_tb_top;
    import cdt_pkg::*;
    localparam int NCH = 2;
    localparam int DIV = 2;

    typedef struct {
        logic [15:0] reload;
        logic undiv;
        logic pin;
        logic use_ack;
    } cdt_row_type;

    // ****************************************
    // Signals
    // ****************************************
    logic clock = 1'b0;
    logic reset = 1'b1;
    cdt_cfg_type [NCH-1:0] cfg = '0;
    logic [NCH-1:0] irq_clear = '0;
    logic [NCH-1:0] irq_ack = '0;
    logic [NCH-1:0] evt_pin = '1;
    logic [NCH-1:0] pin_in = '0;
    logic [NCH-1:0] irq_request;
    logic [NCH-1:0] pulse_pin_out;
    logic [NCH-1:0] pulse_pin_oe_n;
    logic [NCH-1:0] port_level;
    cdt_stat_type [NCH-1:0] stat;
    int n_errors = 0;
    int n_compared = 0;
    int n;
    logic p;
    // Zero reload and the prescaled source are the edge cases of the period
    cdt_row_type rows [4] = '{'{16'h0002, 1'b1, 1'b1, 1'b0}, '{16'h0000, 1'b1, 1'b0, 1'b1},
        '{16'h0003, 1'b0, 1'b1, 1'b1}, '{16'h0005, 1'b1, 1'b0, 1'b0}};

    always #10 clock = ~clock;

    cdt_timers #(.NCH(NCH), .DIV(DIV)) dut_u (.clock(clock), .reset(reset), .cfg(cfg), .irq_clear(irq_clear),
        .irq_ack(irq_ack), .irq_request(irq_request), .timer_event_input_pin(evt_pin), .pulse_pin_in(pin_in),
        .pulse_pin_out(pulse_pin_out), .pulse_pin_oe_n(pulse_pin_oe_n), .port_level(port_level), .stat(stat));

    // ****************************************
    // Tasks
    // ****************************************
    task give_verdict();
        $display("errors %0d compared %0d", n_errors, n_compared);
        if (n_errors == 0 && n_compared > 0) begin
            $display("DONE - PASS");
        end else begin
            $display("DONE - FAIL");
        end
        $finish;
    endtask : give_verdict

    task check_val(input logic [31:0] got, input logic [31:0] exp);
        n_compared++;
        if (got !== exp) begin
            n_errors++;
            $display("mismatch at %0t: got %h expected %h", $time, got, exp);
        end
    endtask : check_val

    task check_bit(input logic got, input logic exp);
        check_val({31'h0, got}, {31'h0, exp});
    endtask : check_bit

    task set_ch(input int ch, input logic go, input cdt_mode_type md, input logic ext, input logic undiv,
        input logic psel, input logic [15:0] rl);
        @(posedge clock);
        cfg[ch] <= '{start: go, mode: md, evt_ext: ext, clk_undiv: undiv, pulse_sel: psel, reload: rl};
    endtask : set_ch

    // Counts falling clock edges up to and including the next underflow
    task wait_uf(input int ch, output int cnt);
        cnt = 0;
        do begin
            @(negedge clock);
            cnt++;
        end while (stat[ch].uf !== 1'b1 && cnt < 200);
        if (stat[ch].uf !== 1'b1) begin
            n_errors++;
            give_verdict();
        end
    endtask : wait_uf

    task clear_irq(input int ch, input logic by_ack);
        @(posedge clock);
        if (by_ack) begin
            irq_ack[ch] <= 1'b1;
        end else begin
            irq_clear[ch] <= 1'b1;
        end
        @(posedge clock);
        irq_ack[ch] <= 1'b0;
        irq_clear[ch] <= 1'b0;
        @(negedge clock);
    endtask : clear_irq

    // Clear is held over several edges since a late underflow would win a one-cycle clear
    task idle();
        @(posedge clock);
        cfg <= '0;
        irq_clear <= '1;
        repeat (3) @(posedge clock);
        irq_clear <= '0;
        @(negedge clock);
    endtask : idle

    // ****************************************
    // Main sequence
    // ****************************************
    initial begin
        repeat (4) @(posedge clock);
        @(negedge clock);
        check_val(irq_request, 0);
        check_val(pulse_pin_oe_n, 2'h3);
        check_val(pulse_pin_out, 0);
        check_val(stat[0].state, CDT_ST_STOP);
        @(posedge clock);
        reset <= 1'b0;
        foreach (rows[i]) begin
            set_ch(0, 1'b1, CDT_MODE_TIMER, 1'b0, rows[i].undiv, 1'b0, rows[i].reload);
            pin_in <= {NCH{rows[i].pin}};
            wait_uf(0, n);
            wait_uf(0, n);
            check_val(n, (rows[i].reload + 1) * (rows[i].undiv ? 1 : DIV));
            check_bit(irq_request[0], 1'b1);
            check_bit(pulse_pin_oe_n[0], 1'b1);
            check_bit(pulse_pin_out[0], 1'b0);
            check_bit(port_level[0], rows[i].pin);
            set_ch(0, 1'b0, CDT_MODE_TIMER, 1'b0, 1'b1, 1'b0, rows[i].reload);
            repeat (4) @(negedge clock);
            check_bit(irq_request[0], 1'b1);
            clear_irq(0, rows[i].use_ack);
            check_bit(irq_request[0], 1'b0);
        end
        idle();
        set_ch(1, 1'b1, CDT_MODE_EVENT, 1'b0, 1'b1, 1'b0, 16'h0002);
        set_ch(0, 1'b1, CDT_MODE_TIMER, 1'b0, 1'b1, 1'b0, 16'h0001);
        wait_uf(1, n);
        wait_uf(1, n);
        check_val(n, 3 * 2);
        idle();
        set_ch(1, 1'b1, CDT_MODE_ONESHOT, 1'b0, 1'b1, 1'b1, 16'h0003);
        set_ch(0, 1'b1, CDT_MODE_TIMER, 1'b0, 1'b1, 1'b0, 16'h0009);
        wait_uf(0, n);
        n = 0;
        repeat (8) begin
            @(negedge clock);
            n += (pulse_pin_out[1] === 1'b1);
        end
        check_val(n, 3);
        check_bit(pulse_pin_out[1], 1'b0);
        check_bit(pulse_pin_oe_n[1], 1'b0);
        check_bit(irq_request[1], 1'b1);
        check_val(stat[1].state, CDT_ST_ARMED);
        check_val(stat[1].count, 16'h0003);
        idle();
        set_ch(0, 1'b1, CDT_MODE_TIMER, 1'b0, 1'b1, 1'b1, 16'h0002);
        wait_uf(0, n);
        @(negedge clock);
        p = pulse_pin_out[0];
        repeat (2) begin
            @(negedge clock);
            check_bit(pulse_pin_out[0], p);
        end
        @(negedge clock);
        check_bit(pulse_pin_out[0], ~p);
        check_bit(pulse_pin_oe_n[0], 1'b0);
        set_ch(0, 1'b1, CDT_MODE_TIMER, 1'b0, 1'b1, 1'b0, 16'h0002);
        repeat (2) @(negedge clock);
        check_bit(pulse_pin_oe_n[0], 1'b1);
        check_bit(pulse_pin_out[0], 1'b0);
        idle();
        set_ch(0, 1'b1, CDT_MODE_EVENT, 1'b1, 1'b1, 1'b0, 16'h0000);
        repeat (4) @(negedge clock);
        check_bit(irq_request[0], 1'b0);
        repeat (2) begin
            @(posedge clock);
            evt_pin[0] <= 1'b0;
            wait_uf(0, n);
            check_val(n, 2);
            @(negedge clock);
            check_bit(irq_request[0], 1'b1);
            clear_irq(0, 1'b0);
            @(posedge clock);
            evt_pin[0] <= 1'b1;
            repeat (3) @(posedge clock);
        end
        // Reset in mid-run drops requests and gives the pin back; start stays set
        idle();
        set_ch(0, 1'b1, CDT_MODE_TIMER, 1'b0, 1'b1, 1'b1, 16'h0001);
        repeat (6) @(negedge clock);
        check_bit(irq_request[0], 1'b1);
        @(posedge clock);
        reset <= 1'b1;
        @(negedge clock);
        check_val(irq_request, 0);
        check_val(pulse_pin_oe_n, 2'h3);
        check_val(pulse_pin_out, 0);
        check_val(stat[0].state, CDT_ST_STOP);
        @(posedge clock);
        reset <= 1'b0;
        repeat (2) @(negedge clock);
        check_val(stat[0].state, CDT_ST_COUNT);
        check_val(stat[0].count, 16'h0001);
        check_bit(pulse_pin_oe_n[0], 1'b0);
        check_bit(irq_request[0], 1'b0);
        give_verdict();
    end
endmodule : cdt_timers_tb_top

`default_nettype wire
